// file: hdl/usbep_ep0_ctrl.sv
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module usbep_ep0_ctrl
#(
	parameter int MPS = usbep_pkg::MAX_PKT
)
(
	input  wire logic               clk_sys,
	input  wire logic               nrst,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [3:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire usbep_pkg::usbep_tok_t tok,
	input  wire logic               rxWr,
	input  wire logic [7:0]         rxData,
	input  wire logic               txRd,
	input  wire logic               inAck,
	output usbep_pkg::usbep_hs_t    hs,
	output logic [7:0]              txData,
	output logic                    fifoDirIn,
	output logic                    ep0Int
);
	import usbep_pkg::*;

	// ===================================================
	// state
	logic [7:0]   mem [MPS];
	logic [5:0]   wrPtr_reg, rdPtr_reg;
	logic [6:0]   cnt_reg, count_reg;
	usbep_state_t state_reg, state_next;
	logic         rxRdy_reg, txRdy_reg, stSent_reg, dDone_reg;
	logic         prem_reg, stReq_reg, stsPend_reg;

	// ===================================================
	// apb decode
	wire apbSetup = psel & ~penable;
	wire apbDone  = psel & penable & pready;
	wire apbWr    = apbDone & pwrite;
	wire apbRd    = apbDone & ~pwrite;
	wire hitCsr   = paddr == CSR_OFS;
	wire hitCnt   = paddr == COUNT_OFS;
	wire hitFifo  = paddr == FIFO_OFS;
	wire mapped   = hitCsr | hitCnt | hitFifo;
	wire csrWr    = apbWr & hitCsr;
	wire swAck    = csrWr & pwdata[B_RXACK];
	wire swPrAck  = csrWr & pwdata[B_PREMACK];
	wire swFifoWr = apbWr & hitFifo & fifoDirIn;
	wire swFifoRd = apbRd & hitFifo & ~fifoDirIn;
	wire [31:0] csrView = {22'h00_0000, state_reg, 1'b0, 1'b0, stReq_reg,
		prem_reg, dDone_reg, stSent_reg, txRdy_reg, rxRdy_reg};
	wire [31:0] rdMux = hitCsr ? csrView
		: hitCnt ? {25'h000_0000, count_reg}
		: hitFifo ? {24'h00_0000, mem[rdPtr_reg]} : 32'h0000_0000;

	// ===================================================
	// link event decode
	wire setupBeg = tok.start & tok.pid == PID_SETUP;
	wire premature_end_flag = tok.finish & tok.pid == PID_SETUP;
	wire setupOk  = premature_end_flag & tok.len == SETUP_LEN;
	wire inBeg    = tok.start & tok.pid == PID_IN;
	wire outEnd   = tok.finish & tok.pid == PID_OUT;
	wire outZero  = tok.len == 7'h00;
	wire outBig   = tok.len > 7'(MPS);
	wire stallSw  = (inBeg | outEnd) & stReq_reg;
	wire inTx     = inBeg & ~stReq_reg & state_reg == EP_TX;
	wire inStatus = inBeg & ~stReq_reg & state_reg != EP_TX & dDone_reg;
	wire inPrem   = inBeg & ~stReq_reg & state_reg == EP_RX & ~dDone_reg;
	wire inStall  = inTx & ~txRdy_reg & dDone_reg;
	wire outRx    = outEnd & ~stReq_reg & state_reg == EP_RX;
	wire outStall = outRx & (dDone_reg | outBig);
	wire outData  = outRx & ~dDone_reg & ~outBig & ~rxRdy_reg;
	wire outTx    = outEnd & ~stReq_reg & state_reg == EP_TX;
	wire outStat  = outTx & dDone_reg & ~txRdy_reg;
	wire outPrem  = outTx & ~outStat & ~dDone_reg & outZero;
	wire outOther = outEnd & ~stReq_reg
		& (state_reg == EP_IDLE | (outTx & ~outStat & ~outPrem));
	wire stallEvt = stallSw | inStall | outStall | (outStat & ~outZero)
		| outOther;
	wire setupPrem = setupBeg & state_reg != EP_IDLE;
	wire premEvt  = inPrem | outPrem | setupPrem;
	wire txSent   = inAck & txRdy_reg & state_reg == EP_TX;
	wire doneEvt  = (inAck & stsPend_reg) | (outStat & outZero & ~outOther);
	wire rxEvt    = setupOk | outData;
	wire wLenZero = mem[6] == 8'h00 & mem[7] == 8'h00;
	wire dirIn    = mem[0][7];
	wire flush    = setupBeg | (premature_end_flag & ~setupOk) | swAck | outPrem;
	wire anyEvt   = rxEvt | txSent | stallEvt | premEvt | doneEvt;

	// ===================================================
	// endpoint state
	always_comb
	begin
		state_next = state_reg;
		if (swAck & rxRdy_reg & state_reg == EP_IDLE)
			state_next = wLenZero ? EP_IDLE : dirIn ? EP_TX : EP_RX;
		if (doneEvt | stallEvt | premEvt | setupBeg)
			state_next = EP_IDLE;
	end
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			state_reg <= EP_IDLE;
		else
			state_reg <= state_next;
	end
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			fifoDirIn <= 1'b0;
		else if (setupBeg | state_next == EP_IDLE)
			fifoDirIn <= 1'b0;
		else if (state_next == EP_TX)
			fifoDirIn <= 1'b1;
	end

	// ===================================================
	// control/status flags, set wins over clear except for tx ready, data done and stall request
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			{stReq_reg, prem_reg, dDone_reg} <= CSR_RST[5:3];
			{stSent_reg, txRdy_reg, rxRdy_reg} <= CSR_RST[2:0];
		end
		else
		begin
			if (swAck)
				rxRdy_reg <= 1'b0;
			if (rxEvt)
				rxRdy_reg <= 1'b1;
			if (csrWr & pwdata[B_TXRDY] & fifoDirIn)
				txRdy_reg <= 1'b1;
			if (txSent | setupBeg | outPrem)
				txRdy_reg <= 1'b0;
			if (csrWr & pwdata[B_STSENT])
				stSent_reg <= 1'b0;
			if (stallEvt)
				stSent_reg <= 1'b1;
			if (csrWr & pwdata[B_DDONE])
				dDone_reg <= 1'b1;
			if (doneEvt | stallEvt | setupBeg | premEvt)
				dDone_reg <= 1'b0;
			if (swPrAck)
				prem_reg <= 1'b0;
			if (premEvt)
				prem_reg <= 1'b1;
			if (csrWr & pwdata[B_STREQ])
				stReq_reg <= 1'b1;
			if (stallSw | setupBeg)
				stReq_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			stsPend_reg <= 1'b0;
		else if (inStatus | inAck | setupBeg)
			stsPend_reg <= inStatus;
	end
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			count_reg <= 7'h00;
		else if (rxEvt)
			count_reg <= tok.len;
	end

	// ===================================================
	// handshake and interrupt
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			hs     <= '0;
			ep0Int <= 1'b0;
		end
		else
		begin
			ep0Int   <= anyEvt;
			hs.valid <= stallEvt | setupOk | outData | outStat | inBeg
				| (outRx & rxRdy_reg) | outPrem;
			hs.len   <= 7'h00;
			if (stallEvt)
				hs.code <= HS_STALL;
			else if (inTx & txRdy_reg)
			begin
				hs.code <= HS_DATA;
				hs.len  <= cnt_reg;
			end
			else if (inStatus)
				hs.code <= HS_DATA;
			else if (inBeg | (outRx & rxRdy_reg))
				hs.code <= HS_NAK;
			else
				hs.code <= HS_ACK;
		end
	end

	// ===================================================
	// endpoint 0 fifo, cpu port is the only software path
	wire linkWr = rxWr & ~fifoDirIn & cnt_reg < 7'(MPS);
	wire linkRd = txRd & fifoDirIn & cnt_reg != 7'h00;
	wire fWr    = linkWr | (swFifoWr & cnt_reg < 7'(MPS));
	wire fRd    = linkRd | (swFifoRd & cnt_reg != 7'h00);
	wire [7:0] fDin = fifoDirIn ? pwdata[7:0] : rxData;

	always_ff @(posedge clk_sys)
	begin
		if (fWr)
			mem[wrPtr_reg] <= fDin;
	end
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			wrPtr_reg <= 6'h00;
			rdPtr_reg <= 6'h00;
			cnt_reg   <= 7'h00;
		end
		else if (flush)
		begin
			wrPtr_reg <= 6'h00;
			rdPtr_reg <= 6'h00;
			cnt_reg   <= 7'h00;
		end
		else
		begin
			wrPtr_reg <= wrPtr_reg + 6'(fWr);
			rdPtr_reg <= rdPtr_reg + 6'(fRd);
			cnt_reg   <= cnt_reg + 7'(fWr) - 7'(fRd);
		end
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			txData <= 8'h00;
		else if (linkRd)
			txData <= mem[rdPtr_reg];
	end

	// ===================================================
	// apb slave, no wait states
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			prdata   <= 32'h0000_0000;
		end
		else
		begin
			pready   <= apbSetup;
			pslverr  <= apbSetup & ~mapped;
			if (apbSetup)
				prdata <= pwrite ? 32'h0000_0000 : rdMux;
		end
	end

	// ===================================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	sequence s_setupOk;
		setupOk & ~setupBeg;
	endsequence
	sequence s_flagInt(f);
		f & ep0Int;
	endsequence

	AST_RX_READY: assert property (s_setupOk |=> s_flagInt(rxRdy_reg))
		else $error("rx ready or interrupt missing after setup");
	AST_TX_SENT: assert property (txSent & ~setupBeg
		|=> ~txRdy_reg & ep0Int)
		else $error("tx ready not cleared after packet sent");
	AST_STALL_FLAG: assert property (hs.valid & hs.code == HS_STALL
		|-> stSent_reg & ep0Int)
		else $error("stall sent without flag and interrupt");
	AST_PREM_END: assert property (premEvt |=> s_flagInt(prem_reg))
		else $error("premature end not flagged");
	AST_OUT_DONE: assert property (outRx & dDone_reg
		|=> hs.valid & hs.code == HS_STALL)
		else $error("out after done not stalled");
	AST_IN_DONE: assert property (inTx & dDone_reg & ~txRdy_reg
		|=> hs.valid & hs.code == HS_STALL & stSent_reg)
		else $error("in after done not stalled");
	AST_STALL_REQ: assert property (stallSw
		|=> hs.code == HS_STALL & ~stReq_reg ##1 ~ep0Int)
		else $error("requested stall not delivered");
	AST_STATUS: assert property (inAck & stsPend_reg & ~setupBeg
		|=> ep0Int & state_reg == EP_IDLE & ~dDone_reg)
		else $error("status completion missing");
	AST_DECODE: assert property (swAck & rxRdy_reg & state_reg == EP_IDLE
		& ~(doneEvt | stallEvt | premEvt | setupBeg) & ~wLenZero & dirIn
		|=> state_reg == EP_TX & fifoDirIn)
		else $error("read request not decoded to transmit");
	AST_REJECT: assert property (premature_end_flag & ~setupOk & ~rxRdy_reg
		|=> ~rxRdy_reg & cnt_reg == 7'h00)
		else $error("bad setup length not rejected");
	AST_ACK_ONESHOT: assert property (swAck & ~rxEvt
		|=> ~rxRdy_reg & ~csrView[B_RXACK])
		else $error("ack did not clear rx ready");
	AST_IDLE_RST: assert property ($rose(nrst) |-> state_reg == EP_IDLE)
		else $error("not idle after reset");
endmodule
`default_nettype wire

// file: hdl/usbep_pkg.sv
`default_nettype none
package usbep_pkg;
	// ===================================================
	// register map and fields
	localparam logic [3:0] CSR_OFS     = 4'h0;
	localparam logic [3:0] COUNT_OFS   = 4'h4;
	localparam logic [3:0] FIFO_OFS    = 4'h8;
	localparam int B_RXRDY   = 0;
	localparam int B_TXRDY   = 1;
	localparam int B_STSENT  = 2;
	localparam int B_DDONE   = 3;
	localparam int B_PREM    = 4;
	localparam int B_STREQ   = 5;
	localparam int B_RXACK   = 6;
	localparam int B_PREMACK = 7;
	localparam int B_STATE   = 8;
	localparam logic [31:0] CSR_RST = 32'h0000_0000;
	// ===================================================
	// link encodings
	localparam logic [1:0] PID_SETUP = 2'h0;
	localparam logic [1:0] PID_OUT   = 2'h1;
	localparam logic [1:0] PID_IN    = 2'h2;
	localparam logic [1:0] HS_ACK    = 2'h0;
	localparam logic [1:0] HS_NAK    = 2'h1;
	localparam logic [1:0] HS_STALL  = 2'h2;
	localparam logic [1:0] HS_DATA   = 2'h3;
	localparam logic [6:0] SETUP_LEN = 7'h08;
	localparam int         MAX_PKT   = 64;
	typedef enum logic [1:0] {
		EP_IDLE = 2'b00,
		EP_TX   = 2'b01,
		EP_RX   = 2'b10
	} usbep_state_t;
	typedef struct packed {
		logic       start;
		logic       finish;
		logic [1:0] pid;
		logic [6:0] len;
	} usbep_tok_t;
	typedef struct packed {
		logic       valid;
		logic [1:0] code;
		logic [6:0] len;
	} usbep_hs_t;
endpackage
`default_nettype wire

// file: test/usbep_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module usbep_host_model
(
	input  wire logic           clk_sys,
	input  wire usbep_pkg::usbep_hs_t hs,
	input  wire logic [7:0]     txData,
	input  wire logic           ep0Int,
	output usbep_pkg::usbep_tok_t tok,
	output logic                rxWr,
	output logic [7:0]          rxData,
	output logic                txRd,
	output logic                inAck
);
	import usbep_pkg::*;
	logic [1:0] hsCode;
	logic [6:0] hsLen;
	logic       hsInt;
	logic       gotHs;
	logic       ackInt;
	logic [7:0] got[$];
	initial
	begin
		tok = '0;
		rxWr = 1'b0;
		rxData = 8'h00;
		txRd = 1'b0;
		inAck = 1'b0;
	end
	// ===================================================
	// handshake capture
	task automatic wait_hs();
		hsCode = 2'bxx;
		hsInt = 1'b0;
		gotHs = 1'b0;
		for (int i = 0; i < 10 && !gotHs; i++)
		begin
			@(negedge clk_sys);
			gotHs = (hs.valid === 1'b1);
			hsCode = hs.code;
			hsLen = hs.len;
			hsInt = ep0Int;
		end
		if (!gotHs)
			hsCode = 2'bxx;
	endtask
	// ===================================================
	// setup and out packets
	task automatic pkt(input logic [1:0] p, input logic [7:0] b[$]);
		@(posedge clk_sys);
		tok <= '{1'b1, 1'b0, p, 7'h00};
		foreach (b[i])
		begin
			@(posedge clk_sys);
			tok.start <= 1'b0;
			rxWr <= 1'b1;
			rxData <= b[i];
		end
		@(posedge clk_sys);
		rxWr <= 1'b0;
		rxData <= ~rxData;
		tok <= '{1'b0, 1'b1, p, 7'(b.size())};
		@(posedge clk_sys);
		tok <= '0;
		wait_hs();
	endtask
	// ===================================================
	// in token, pulls data and acknowledges it when the handshake is DATA
	task automatic in_tok();
		@(posedge clk_sys);
		tok <= '{1'b1, 1'b0, PID_IN, 7'h00};
		@(posedge clk_sys);
		tok <= '0;
		wait_hs();
		got = {};
		ackInt = 1'b0;
		if (hsCode === HS_DATA)
		begin
			for (int i = 0; i < int'(hsLen); i++)
			begin
				@(posedge clk_sys);
				txRd <= 1'b1;
				@(posedge clk_sys);
				txRd <= 1'b0;
				@(negedge clk_sys);
				got.push_back(txData);
			end
			@(posedge clk_sys);
			inAck <= 1'b1;
			@(posedge clk_sys);
			inAck <= 1'b0;
			for (int i = 0; i < 4; i++)
			begin
				@(negedge clk_sys);
				ackInt = ackInt | (ep0Int === 1'b1);
			end
		end
	endtask
endmodule
`default_nettype wire

// file: test/tb_usb_ep0_control_transfer.sv
`timescale 1ns/10ps
`default_nettype none
module tb_usb_ep0_control_transfer;
	import usbep_pkg::*;
	logic        clk_sys, nrst, psel, penable, pwrite, pready, pslverr;
	logic        rxWr, txRd, inAck, fifoDirIn, ep0Int, err;
	logic [3:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  rxData, txData;
	usbep_tok_t  tok;
	usbep_hs_t   hs;
	int          fails, n_tests;
	usbep_ep0_ctrl #(.MPS(64)) DUT (.clk_sys(clk_sys), .nrst(nrst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tok(tok), .rxWr(rxWr), .rxData(rxData),
		.txRd(txRd), .inAck(inAck), .hs(hs), .txData(txData),
		.fifoDirIn(fifoDirIn), .ep0Int(ep0Int));
	usbep_host_model HOST (.clk_sys(clk_sys), .hs(hs), .txData(txData),
		.ep0Int(ep0Int), .tok(tok), .rxWr(rxWr), .rxData(rxData),
		.txRd(txRd), .inAck(inAck));
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// ===================================================
	// checking and apb tasks
	task automatic complete_run();
		if (fails == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_tests++;
		if (s !== e)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int i;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge clk_sys);
			i++;
		end
		while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1)
		begin
			fails++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rc(input logic [3:0] a, input logic [31:0] m, e);
		apb(1'b0, a, 32'h0000_0000);
		chk($sformatf("reg %h", a), rd & m, e);
	endtask
	task automatic hc(input logic [1:0] c, input logic i);
		chk("hs code", 32'(HOST.hsCode), 32'(c));
		chk("hs irq", 32'(HOST.hsInt), 32'(i));
	endtask
	task automatic req(input logic [7:0] b0, wl, input logic [31:0] ak);
		HOST.pkt(PID_SETUP, '{b0, 8'h06, 8'h00, 8'h01, 8'h00, 8'h00, wl,
			8'h00});
		hc(HS_ACK, 1'b1);
		rc(CSR_OFS, 32'h0000_0001, 32'h0000_0001);
		wr(CSR_OFS, ak);
	endtask
	task automatic stl();
		hc(HS_STALL, 1'b1);
		rc(CSR_OFS, 32'h0000_0004, 32'h0000_0004);
		wr(CSR_OFS, 32'h0000_0004);
	endtask
	// ===================================================
	// main sequence
	initial
	begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 4'h0;
		pwdata = 32'h0000_0000;
		fails = 0;
		n_tests = 0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		rc(CSR_OFS, 32'hFFFF_FFFF, CSR_RST);
		apb(1'b0, 4'hC, 32'h0000_0000);
		chk("slverr", 32'(err), 32'h0000_0001);
		HOST.pkt(PID_SETUP, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
		chk("short setup", 32'(HOST.gotHs), 32'h0000_0000);
		rc(CSR_OFS, 32'h0000_0001, 32'h0000_0000);
		req(8'h00, 8'h00, 32'h0000_0048);
		rc(CSR_OFS, 32'h0000_0349, 32'h0000_0008);
		HOST.in_tok();
		chk("status", 32'(HOST.hsCode), 32'(HS_DATA));
		chk("status irq", 32'(HOST.ackInt), 32'h0000_0001);
		req(8'h00, 8'h02, 32'h0000_0040);
		rc(CSR_OFS, 32'h0000_0301, 32'h0000_0200);
		chk("dir", 32'(fifoDirIn), 32'h0000_0000);
		HOST.pkt(PID_OUT, '{8'hA5, 8'h3C});
		hc(HS_ACK, 1'b1);
		rc(COUNT_OFS, 32'h0000_007F, 32'h0000_0002);
		rc(FIFO_OFS, 32'h0000_00FF, 32'h0000_00A5);
		rc(FIFO_OFS, 32'h0000_00FF, 32'h0000_003C);
		wr(CSR_OFS, 32'h0000_0048);
		HOST.pkt(PID_OUT, '{8'h01});
		stl();
		req(8'h80, 8'h04, 32'h0000_0040);
		rc(CSR_OFS, 32'h0000_0300, 32'h0000_0100);
		chk("dir", 32'(fifoDirIn), 32'h0000_0001);
		wr(FIFO_OFS, 32'h0000_0011);
		wr(FIFO_OFS, 32'h0000_0022);
		wr(CSR_OFS, 32'h0000_000A);
		HOST.in_tok();
		chk("in len", 32'(HOST.hsLen), 32'h0000_0002);
		chk("in data", {HOST.got[0], HOST.got[1]}, 32'h0000_1122);
		chk("sent irq", 32'(HOST.ackInt), 32'h0000_0001);
		rc(CSR_OFS, 32'h0000_0002, 32'h0000_0000);
		HOST.in_tok();
		stl();
		req(8'h80, 8'h04, 32'h0000_0060);
		HOST.in_tok();
		stl();
		req(8'h80, 8'h04, 32'h0000_0040);
		HOST.pkt(PID_SETUP, '{8'h80, 8'h06, 8'h00, 8'h01, 8'h00, 8'h00,
			8'h04, 8'h00});
		chk("prem irq", 32'(HOST.hsInt), 32'h0000_0001);
		rc(CSR_OFS, 32'h0000_0010, 32'h0000_0010);
		complete_run();
	end
endmodule
`default_nettype wire
